// ==== bipb_pkg.sv ====
/*
 Shared constants and types of the BCD instrument port bridge.
 Assumes nothing; imported by every module of the block except bipb_fifo and bipb_instr_model.
*/
package bipb_pkg;
  localparam int unsigned NPORT   = 12;
  localparam int unsigned NIB     = 4;
  localparam int unsigned PW      = NPORT * NIB;
  localparam int unsigned NCH     = 2;
  localparam int unsigned FIFO_W  = 8;
  localparam int unsigned FIFO_D  = 8;
  // host control word fields
  localparam int unsigned CR_ORDER = 0;
  localparam int unsigned CR_END   = 1;
  localparam int unsigned CR_RST   = 2;
  localparam int unsigned CR_IRQ   = 3;
  localparam int unsigned CR_NEG   = 4;
  localparam int unsigned CR_FAST  = 5;
  // host status word fields
  localparam int unsigned SR_IBF  = 0;
  localparam int unsigned SR_BUSY = 1;
  localparam int unsigned SR_END  = 2;
  localparam int unsigned SR_ACK  = 3;
  localparam int unsigned SR_OBF  = 7;
  // order byte fields
  localparam int unsigned CMD_OUT  = 7;
  localparam int unsigned CMD_CHB  = 6;
  localparam int unsigned CMD_LEAD = 5;
  localparam int unsigned CMD_SIGN = 4;
  localparam int unsigned SIGN_BIT_A = 44;
  localparam int unsigned SIGN_BIT_B = 45;
  localparam logic [3:0] SIGN_PORT   = 4'hB;
  localparam logic [3:0] PORT_FIRST  = 4'h0;
  localparam logic [3:0] CNT_ONE     = 4'h1;
  localparam logic [7:0] ASC_ZERO    = 8'h30;
  localparam logic [7:0] ASC_PLUS    = 8'h2B;
  localparam logic [7:0] ASC_MINUS   = 8'h2D;
  localparam logic [7:0] ASC_COMMA   = 8'h2C;
  localparam logic [7:0] ASC_SPACE   = 8'h20;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_REQ, ST_WAIT, ST_SIGN, ST_EMIT
  } bipb_state_t;
endpackage : bipb_pkg

// ==== bipb_flag_sync.sv ====
/*
 Two-stage synchroniser and edge detector for the peripheral response lines.
 Assumes the lines change freely relative to i_mclk.
*/
`timescale 1ns/100ps
module bipb_flag_sync (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_b,
  input  wire logic [bipb_pkg::NCH-1:0]    i_line,
  output logic      [bipb_pkg::NCH-1:0]    o_rise,
  output logic      [bipb_pkg::NCH-1:0]    o_fall
);
  import bipb_pkg::*;
  typedef struct packed {
    logic [NCH-1:0] meta;
    logic [NCH-1:0] sync;
    logic [NCH-1:0] last;
  } bipb_sync_t;
  bipb_sync_t s, next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = i_line;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // edges only from the settled stages
  assign o_rise = s.sync & ~s.last;
  assign o_fall = ~s.sync & s.last;
endmodule : bipb_flag_sync

// ==== bipb_fifo.sv ====
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes one clock; push and pop may occur in the same cycle.
*/
`timescale 1ns/100ps
module bipb_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst_b,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } bipb_fifo_t;
  bipb_fifo_t s, next_s;
  logic push, pop;

  assign o_in_ready  = (s.cnt != (AW+1)'(D));
  assign o_out_valid = (s.cnt != '0);
  assign o_out_data  = s.mem[s.rp];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = i_in_data;
      next_s.wp        = (s.wp == AW'(D-1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : bipb_fifo

// ==== bipb_bridge.sv ====
/*
 Host register bridge plus hardware transfer engine for twelve BCD ports.
 Assumes a synchronous host strobe bus and instruments on two channels.
*/
`timescale 1ns/100ps
module bipb_bridge (
  input  wire logic                       i_mclk,
  input  wire logic                       i_rst_b,
  input  wire logic [2:0]                 i_select_code_bit,
  input  wire logic [3:0]                 i_host_addr,
  input  wire logic                       i_host_wr,
  input  wire logic                       i_host_rd,
  input  wire logic [7:0]                 i_host_wdata,
  output logic      [7:0]                 o_host_rdata,
  output logic                            o_host_irq,
  output logic                            o_host_halt,
  input  wire logic [bipb_pkg::PW-1:0]    i_port_data,
  output logic      [bipb_pkg::PW-1:0]    o_port_data,
  output logic      [bipb_pkg::PW-1:0]    o_port_oe,
  output logic      [bipb_pkg::NCH-1:0]   o_dir_line,
  output logic      [bipb_pkg::NCH-1:0]   o_request_line,
  input  wire logic [bipb_pkg::NCH-1:0]   i_peripheral_response_line
);
  import bipb_pkg::*;

  typedef struct packed {
    bipb_state_t       st;
    logic [7:0]        host_control_word;
    logic [7:0]        host_out_buffer;
    logic [7:0]        host_in_buffer;
    logic              out_buffer_full;
    logic              in_buffer_full;
    logic              busy;
    logic              controller_end_of_transfer;
    logic              controller_irq_ack;
    logic              service;
    logic              host_stall_enable;
    logic              halt;
    logic [7:0]        rdata;
    logic [7:0]        order;
    logic [7:0]        byte_l;
    logic              end_l;
    logic [3:0]        ptr;
    logic [3:0]        cnt;
    logic [PW-1:0]     sample;
    logic [PW-1:0]     pdata;
    logic [NPORT-1:0]  oe;
    logic [NCH-1:0]    dir;
    logic [NCH-1:0]    req;
  } bipb_bridge_t;
  bipb_bridge_t s, next_s;

  logic [NCH-1:0] flag_rise, flag_fall;
  logic           fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0]     fifo_in_data, fifo_out_data;
  logic           hit, ctrl_reset, controller_test_input;
  logic           ch, neg;
  logic [3:0]     last_cnt;
  logic [7:0]     host_status_word;

  bipb_flag_sync u_sync (
    .i_mclk (i_mclk),
    .i_rst_b(i_rst_b),
    .i_line (i_peripheral_response_line),
    .o_rise (flag_rise),
    .o_fall (flag_fall)
  );

  // converted characters queue here so the engine can run ahead of the host
  bipb_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .i_mclk     (i_mclk),
    .i_rst_b    (i_rst_b),
    .i_in_valid (fifo_in_valid),
    .o_in_ready (fifo_in_ready),
    .i_in_data  (fifo_in_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data (fifo_out_data)
  );

  assign hit                   = (i_host_addr[3:1] == i_select_code_bit);
  assign ctrl_reset            = s.host_control_word[CR_RST];
  assign controller_test_input = s.host_control_word[CR_IRQ];
  assign ch                    = s.order[CMD_CHB];
  assign neg                   = s.host_control_word[CR_NEG];
  assign last_cnt              = s.order[3:0] - CNT_ONE;
  assign fifo_out_ready        = ~s.in_buffer_full;
  assign host_status_word      = {s.out_buffer_full, 3'h0, s.controller_irq_ack,
                                  s.controller_end_of_transfer, s.busy,
                                  s.in_buffer_full};

  always_comb begin
    next_s        = s;
    fifo_in_valid = 1'b0;
    fifo_in_data  = ASC_ZERO;
    next_s.rdata  = 8'h00;
    // host side register bridge
    if (i_host_wr && hit) begin
      if (!i_host_addr[0]) begin
        next_s.host_control_word = i_host_wdata;
      end else begin
        next_s.host_out_buffer = i_host_wdata;
      end
    end
    if (i_host_rd && hit) begin
      if (!i_host_addr[0]) begin
        next_s.rdata   = host_status_word;
        next_s.service = 1'b0;
      end else begin
        next_s.rdata          = s.host_in_buffer;
        next_s.in_buffer_full = 1'b0;
      end
    end
    if (fifo_out_valid && !s.in_buffer_full) begin
      next_s.host_in_buffer = fifo_out_data;
      next_s.in_buffer_full = 1'b1;
    end
    // transfer engine
    case (s.st)
      ST_IDLE: begin
        next_s.busy = 1'b0;
        if (controller_test_input && !s.controller_irq_ack) begin
          next_s.controller_irq_ack = 1'b1;
        end else if (s.out_buffer_full) begin
          next_s.busy            = 1'b1;
          next_s.byte_l          = s.host_out_buffer;
          next_s.end_l           = s.host_control_word[CR_END];
          next_s.out_buffer_full = 1'b0;
          next_s.st              = ST_DECODE;
          if (s.host_control_word[CR_ORDER]) begin
            next_s.order = s.host_out_buffer;
          end
        end
        if (!controller_test_input) begin
          next_s.controller_irq_ack = 1'b0;
        end
      end
      ST_DECODE: begin
        next_s.st = ST_IDLE;
        if (s.host_control_word[CR_ORDER]) begin
          next_s.cnt                        = '0;
          next_s.controller_end_of_transfer = 1'b0;
          next_s.host_stall_enable          = s.host_control_word[CR_FAST];
          next_s.ptr = ch ? (SIGN_PORT - s.order[3:0]) : PORT_FIRST;
          next_s.dir[ch] = s.order[CMD_OUT];
          if (s.order[CMD_OUT]) begin
            next_s.oe = '1;
            next_s.pdata[ch ? SIGN_BIT_B : SIGN_BIT_A] = neg;
          end else begin
            next_s.oe = '0;
            next_s.st = ST_REQ;
          end
        end else if (s.order[CMD_OUT]) begin
          if (s.byte_l == ASC_PLUS || s.byte_l == ASC_MINUS) begin
            // sign line level is the wanted truth xor the logic sense
            next_s.pdata[ch ? SIGN_BIT_B : SIGN_BIT_A] =
              (s.byte_l == ASC_MINUS) ^ neg;
          end else if (s.byte_l > ASC_SPACE && s.byte_l != ASC_COMMA) begin
            next_s.pdata[s.ptr*NIB +: NIB] = s.byte_l[3:0];
            next_s.ptr = s.ptr + CNT_ONE;
            next_s.cnt = s.cnt + CNT_ONE;
            if (s.cnt == last_cnt) begin
              next_s.st = ST_REQ;
            end
          end
          if (s.end_l) begin
            next_s.st = ST_REQ;
          end
        end
      end
      ST_REQ: begin
        next_s.req[ch] = 1'b1;
        next_s.st      = ST_WAIT;
      end
      ST_WAIT: begin
        if (s.order[CMD_LEAD] && flag_rise[ch]) begin
          next_s.req[ch] = 1'b0;
        end
        if (flag_fall[ch]) begin
          next_s.req[ch] = 1'b0;
          if (s.order[CMD_OUT]) begin
            next_s.controller_end_of_transfer = 1'b1;
            next_s.service                    = 1'b1;
            next_s.host_stall_enable          = 1'b0;
            next_s.st                         = ST_IDLE;
          end else begin
            next_s.sample = i_port_data;
            next_s.st     = s.order[CMD_SIGN] ? ST_SIGN : ST_EMIT;
          end
        end
      end
      ST_SIGN: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = (s.sample[ch ? SIGN_BIT_B : SIGN_BIT_A] ^ neg) ?
                        ASC_MINUS : ASC_PLUS;
        if (fifo_in_ready) begin
          next_s.st = ST_EMIT;
        end
      end
      ST_EMIT: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = ASC_ZERO | {4'h0, s.sample[s.ptr*NIB +: NIB]};
        if (fifo_in_ready) begin
          next_s.ptr = s.ptr + CNT_ONE;
          next_s.cnt = s.cnt + CNT_ONE;
          if (s.cnt == last_cnt) begin
            next_s.controller_end_of_transfer = 1'b1;
            next_s.service                    = 1'b1;
            next_s.host_stall_enable          = 1'b0;
            next_s.st                         = ST_IDLE;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // host byte lands after the engine took the old one, so a set wins
    if (i_host_wr && hit && i_host_addr[0]) begin
      next_s.out_buffer_full = 1'b1;
    end
    // the host's reset bit holds the engine and the lines quiet
    if (ctrl_reset) begin
      next_s.st                         = ST_IDLE;
      next_s.busy                       = 1'b0;
      next_s.oe                         = '0;
      next_s.dir                        = '0;
      next_s.req                        = '0;
      next_s.controller_end_of_transfer = 1'b0;
      next_s.controller_irq_ack         = 1'b0;
      next_s.host_stall_enable          = 1'b0;
    end
    // halting keeps a fast host from overrunning the out buffer or reading an empty in buffer
    next_s.halt = next_s.host_stall_enable &
                  (next_s.out_buffer_full | ~next_s.in_buffer_full);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_host_rdata   = s.rdata;
  assign o_host_irq     = s.service;
  assign o_host_halt    = s.halt;
  assign o_port_data    = s.pdata;
  assign o_dir_line     = s.dir;
  assign o_request_line = s.req;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_oe
      assign o_port_oe[g*NIB +: NIB] = {NIB{s.oe[g]}};
    end
  endgenerate

  AST_MISS_NO_OBF: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_host_wr && !hit && !s.out_buffer_full) |=> !s.out_buffer_full)
    else $error("out buffer filled by a write to another select code");
  AST_OB_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_host_wr && hit && i_host_addr[0]) |=> s.out_buffer_full)
    else $error("out buffer write did not set out-full");
  AST_STATUS_ZEROS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_host_rd && hit && !i_host_addr[0]) |=>
      (o_host_rdata[6:4] == 3'h0 && o_host_rdata[7] == $past(s.out_buffer_full)))
    else $error("status read layout wrong");
  AST_IB_READ: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_host_rd && hit && i_host_addr[0] && s.in_buffer_full) |=>
      (o_host_rdata == $past(s.host_in_buffer)))
    else $error("in buffer read returned wrong byte");
  AST_RESET_BIT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    ctrl_reset |=> (o_port_oe == '0 && o_request_line == '0 && !s.busy))
    else $error("reset bit left lines driven");
  AST_BUSY_RISE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_IDLE && s.out_buffer_full && !ctrl_reset &&
     !(controller_test_input && !s.controller_irq_ack)) |=> s.busy[*2])
    else $error("busy not raised for a waiting byte");
  AST_ACK: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_IDLE && controller_test_input && !s.controller_irq_ack && !ctrl_reset)
      |=> s.controller_irq_ack)
    else $error("interrupt not acknowledged");
  AST_LEAD_DROP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_WAIT && s.order[CMD_LEAD] && flag_rise[ch] && !ctrl_reset)
      |=> !o_request_line[$past(ch)])
    else $error("leading mode request not dropped");
  AST_ASCII: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_EMIT) |-> (fifo_in_data[7:4] == 4'h3))
    else $error("digit not converted to ASCII");
  AST_ONE_CHANNEL: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !(o_request_line[0] && o_request_line[1]))
    else $error("both channels requesting");
  COV_INPUT: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_EMIT) ##1 (s.st == ST_IDLE));
  COV_OUTPUT: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    (s.st == ST_WAIT && s.order[CMD_OUT] && flag_fall[ch]));
  COV_FIFO_FULL: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    (fifo_in_valid && !fifo_in_ready));
endmodule : bipb_bridge

// ==== bipb_instr_model.sv ====
/*
 Instrument model for both channels: answers each request with a flag pulse.
 Assumes request lines from the bridge and a reading supplied by the bench.
*/
`timescale 1ns/100ps
module bipb_instr_model #(
  parameter int HOLD = 600
) (
  input  wire logic        i_mclk,
  input  wire logic [1:0]  i_request_line,
  input  wire logic [47:0] i_port_oe,
  input  wire logic [47:0] i_port_out,
  input  wire logic [47:0] i_reading,
  output logic      [1:0]  o_flag,
  output logic      [47:0] o_port_in,
  output logic      [47:0] o_latched
);
  logic [47:0] shown = '0;
  // stale inverse while measuring, so an early sample is caught
  assign o_port_in = (i_port_oe & i_port_out) | (~i_port_oe & shown);
  for (genvar c = 0; c < 2; c++) begin : g_ch
    initial begin
      o_flag[c] = 1'b0;
      forever begin
        @(posedge i_request_line[c]);
        shown = ~i_reading;
        repeat (4) @(posedge i_mclk);
        o_latched = i_port_out;
        o_flag[c] <= 1'b1;
        repeat (HOLD) @(posedge i_mclk);
        shown = i_reading;
        @(posedge i_mclk);
        o_flag[c] <= 1'b0;
      end
    end
  end
endmodule : bipb_instr_model

// ==== tb.sv ====
/*
 Self-checking bench of the port bridge with a queue model of host bytes.
 Assumes the design files and the instrument model are compiled first.
*/
`timescale 1ns/100ps
module tb;
  import bipb_pkg::*;
  localparam logic [2:0] SC = 3'h5;
  logic          i_mclk       = 1'b0;
  logic          i_rst_b      = 1'b0;
  logic [3:0]    i_host_addr  = 4'h0;
  logic          i_host_wr    = 1'b0;
  logic          i_host_rd    = 1'b0;
  logic [7:0]    i_host_wdata = 8'h00;
  logic [7:0]    o_host_rdata, rd;
  logic          o_host_irq, o_host_halt;
  logic [PW-1:0] port_in, port_out, port_oe, latched;
  logic [PW-1:0] reading      = '0;
  logic [1:0]    dir, req, flag;
  logic [7:0]    exq[$];
  int            err_count    = 0;
  int            checked      = 0;

  always #12.5 i_mclk = ~i_mclk;

  bipb_bridge dut (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_select_code_bit(SC),
    .i_host_addr(i_host_addr), .i_host_wr(i_host_wr), .i_host_rd(i_host_rd),
    .i_host_wdata(i_host_wdata), .o_host_rdata(o_host_rdata),
    .o_host_irq(o_host_irq), .o_host_halt(o_host_halt),
    .i_port_data(port_in), .o_port_data(port_out), .o_port_oe(port_oe),
    .o_dir_line(dir), .o_request_line(req), .i_peripheral_response_line(flag)
  );

  bipb_instr_model #(.HOLD(600)) instr (
    .i_mclk(i_mclk), .i_request_line(req), .i_port_oe(port_oe),
    .i_port_out(port_out), .i_reading(reading), .o_flag(flag),
    .o_port_in(port_in), .o_latched(latched)
  );

  task automatic report_and_stop;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
  endtask : cmp

  task automatic hwr(input logic a0, input logic [7:0] d, input logic [2:0] sc = SC);
    @(negedge i_mclk);
    i_host_addr  = {sc, a0};
    i_host_wdata = d;
    i_host_wr    = 1'b1;
    @(negedge i_mclk);
    i_host_wr    = 1'b0;
  endtask : hwr

  task automatic hrd(input logic a0, output logic [7:0] d, input logic [2:0] sc = SC);
    @(negedge i_mclk);
    i_host_addr = {sc, a0};
    i_host_rd   = 1'b1;
    @(negedge i_mclk);
    i_host_rd   = 1'b0;
    d = o_host_rdata;
  endtask : hrd

  // bounded status poll; running out of tries ends the run
  task automatic poll(input int b, input logic val);
    for (int n = 0; n < 2000; n++) begin
      hrd(1'b0, rd);
      if (rd[b] === val) begin
        checked++;
        return;
      end
    end
    err_count++;
    $display("mismatch status_bit%0d exp %0b got %0b", b, val, rd[b]);
    report_and_stop();
  endtask : poll

  // engine must be idle first: a write into a full out buffer overwrites
  task automatic hput(input logic a0, input logic [7:0] d);
    poll(SR_OBF, 1'b0);
    poll(SR_BUSY, 1'b0);
    hwr(a0, d);
  endtask : hput

  task automatic run_in(input logic [7:0] order, input logic neg, input int stall,
                        input logic fast = 1'b0);
    int cnt;
    int base;
    logic s;
    cnt = int'(order[3:0]);
    base = order[CMD_CHB] ? int'(NPORT) - 1 - cnt : 0;
    reading = PW'({$urandom, $urandom});
    s = order[CMD_CHB] ? reading[SIGN_BIT_B] : reading[SIGN_BIT_A];
    if (order[CMD_SIGN]) exq.push_back((s ^ neg) ? ASC_MINUS : ASC_PLUS);
    for (int p = base; p < base + cnt; p++) exq.push_back(ASC_ZERO | 8'(reading[4*p +: 4]));
    hput(1'b0, {2'h0, fast, neg, 4'h1});
    hput(1'b1, order);
    // stall is armed at decode and the in buffer is still empty
    if (fast) begin
      repeat (3) @(negedge i_mclk);
      cmp("halt", 1'b1, o_host_halt);
    end
    repeat (stall) @(negedge i_mclk);
    while (exq.size() > 0) begin
      poll(SR_IBF, 1'b1);
      hrd(1'b1, rd);
      cmp("in_byte", exq.pop_front(), rd);
    end
    cmp("request", 2'b00, req);
    cmp("dir", 2'b00, dir);
    cmp("halt_end", 1'b0, o_host_halt);
  endtask : run_in

  task automatic run_out(input logic [7:0] order, input logic [7:0] b[],
                         input logic [7:0] cw = 8'h00);
    hput(1'b0, 8'h01);
    hput(1'b1, order);
    hput(1'b0, cw);
    foreach (b[i]) hput(1'b1, b[i]);
    for (int n = 0; n < 2000 && o_host_irq !== 1'b1; n++) @(negedge i_mclk);
    cmp("irq", 1'b1, o_host_irq);
    if (o_host_irq !== 1'b1) report_and_stop();
    cmp("dir_a", 1'b1, dir[0]);
    hrd(1'b0, rd);
    cmp("end", 1'b1, rd[SR_END]);
    @(negedge i_mclk);
    cmp("irq_clr", 1'b0, o_host_irq);
  endtask : run_out

  initial begin
    void'($urandom(32'h93AE));
    repeat (8) @(negedge i_mclk);
    i_rst_b = 1'b1;
    cmp("oe", '0, port_oe);
    cmp("request", 2'b00, req);
    hrd(1'b0, rd);
    cmp("status", 8'h00, rd);
    hwr(1'b0, 8'h01, 3'h2);
    hwr(1'b1, 8'h01, 3'h2);
    repeat (10) @(negedge i_mclk);
    cmp("foreign_req", 2'b00, req);
    hrd(1'b0, rd, 3'h2);
    cmp("foreign_rd", 8'h00, rd);
    run_in(8'h1B, 1'b0, 900);
    run_in(8'h72, 1'b1, 0);
    run_in(8'h03, 1'b0, 0);
    run_in(8'h01, 1'b0, 0, 1'b1);
    run_out(8'h92, '{8'h20, ASC_MINUS, 8'h35, ASC_COMMA, 8'h0D, 8'h3A});
    cmp("port0", 4'h5, latched[3:0]);
    cmp("port1", 4'hA, latched[7:4]);
    cmp("sign", 1'b1, latched[SIGN_BIT_A]);
    cmp("oe_out", 8'hFF, port_oe[7:0]);
    // count of two cut short by the end bit after one digit
    run_out(8'h82, '{8'h37}, 8'h02);
    cmp("port0", 4'h7, latched[3:0]);
    cmp("sign", 1'b0, latched[SIGN_BIT_A]);
    @(negedge i_mclk);
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_rst_b = 1'b1;
    cmp("oe_hwrst", '0, port_oe);
    cmp("dir_hwrst", 2'b00, dir);
    hrd(1'b0, rd);
    cmp("status_hwrst", 8'h00, rd);
    run_out(8'h91, '{ASC_PLUS, 8'h34});
    cmp("port0", 4'h4, latched[3:0]);
    cmp("sign", 1'b0, latched[SIGN_BIT_A]);
    hput(1'b0, 8'h04);
    repeat (2) @(negedge i_mclk);
    cmp("oe_rst", '0, port_oe);
    cmp("dir_rst", 2'b00, dir);
    hwr(1'b0, 8'h00);
    hwr(1'b0, 8'h08);
    poll(SR_ACK, 1'b1);
    hwr(1'b0, 8'h00);
    poll(SR_ACK, 1'b0);
    report_and_stop();
  end
endmodule : tb
